//--- shared/lsi_consts.vh
`ifndef LSI_CONSTS_VH
`define LSI_CONSTS_VH
// Bus address and pointer values
`define LSI_DEV_ADDR      7'h45
`define LSI_PTR_RESULT    8'h00
`define LSI_PTR_CONFIG    8'h01
// Configuration field positions
`define LSI_RN_HI         15
`define LSI_RN_LO         12
`define LSI_CT_BIT        11
`define LSI_M_HI          10
`define LSI_M_LO          9
`define LSI_CRF_BIT       7
// Reset values and codes
`define LSI_CFG_RESET     16'hC810
`define LSI_RN_AUTO       4'hC
`define LSI_MODE_SHUT     2'h0
`define LSI_MODE_SINGLE   2'h1
// Timing in native units
`define LSI_CLK_MHZ       200
`define LSI_TIMEOUT_MS    28
`define LSI_SHORT_MS      100
`define LSI_LONG_MS       800
`define LSI_READY_MS      3
`define LSI_MS_CYCLES     (`LSI_CLK_MHZ * 1000)
`endif

//--- rtl/lsi_slave.v
// Notes on behaviour
// [RULE1] SCL held low for 28 ms resets the bus state machine.
// [RULE2] Master makes clock, starts and stops; device never drives SCL.
// [RULE3] Start is SDA falling while SCL high; device detects it.
// [RULE4] Address shifted in on SCL rising edges; last bit is direction.
// [RULE5] Addressed device pulls SDA low in the ninth clock pulse.
// [RULE6] Every transfer is eight data bits then one acknowledge bit.
// [RULE7] SDA change while SCL high is taken as start or stop.
// [RULE8] Stop is SDA rising while SCL high; device detects it.
// [RULE9] Light is integrated over a short or a long window.
// [RULE10] Conversion time select one means 800 ms, zero 100 ms.
// [RULE11] Range number field code 1100b selects automatic range.
// [RULE12] In automatic range device picks full scale per measurement.
// [RULE13] Power up in shutdown; measure only after active mode written.
// [RULE14] Continuous or single-shot conversions selected by mode field.
// [RULE15] Completed result is readable over the serial bus.
// [RULE16] Device answers only to seven-bit address 1000101.
// [RULE17] Write: address, pointer, then two data bytes MSB first, all acked.
// [RULE18] Pointer kept; reads use it until a later write changes it.
// [RULE19] Result readable 3 ms after the integration window ends.
// [RULE20] In shutdown no conversion starts and result stays unchanged.
`include "lsi_consts.vh"
`default_nettype none
module lsi_slave #(
	parameter integer MS_CYCLES = `LSI_MS_CYCLES
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Bus pins (SCL input only)
	input  wire        scl_in,
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe,
	// Optical front end
	input  wire [15:0] adc_code,
	output reg  [3:0]  range_sel,
	output reg         integrating
);
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_RX   = 2'h1;
	localparam [1:0] S_TX   = 2'h2;
	localparam [1:0] S_ACK  = 2'h3;
	localparam [31:0] MS_W  = MS_CYCLES;
	localparam [3:0]  RN_MAX = 4'hB;

	reg [1:0]  scl_s_reg;
	reg [1:0]  sda_s_reg;
	reg        scl_d_reg;
	reg        sda_d_reg;
	reg [1:0]  state_reg;
	reg [3:0]  bit_reg;
	reg [7:0]  sh_reg;
	reg [1:0]  byte_reg;
	reg        rw_reg;
	reg        ack_me_reg;
	reg        mack_reg;
	reg [7:0]  ptr_reg;
	reg [7:0]  hi_reg;
	reg [15:0] cfg_reg;
	reg [15:0] result_reg;
	reg [15:0] txw_reg;
	reg [31:0] to_cnt_reg;
	reg [31:0] ms_cnt_reg;
	reg [9:0]  ms_left_reg;
	reg        busy_reg;
	reg        ms_tick_reg;
	reg        cfg_wr_reg;
	reg [15:0] cfg_wdata_reg;

	wire scl = scl_s_reg[1];
	wire sda = sda_s_reg[1];
	wire scl_rise = scl & ~scl_d_reg;
	wire scl_fall = ~scl & scl_d_reg;
	// [RULE3] [RULE7] start detect
	wire start_c = scl & scl_d_reg & sda_d_reg & ~sda;
	// [RULE8] [RULE7] stop detect
	wire stop_c = scl & scl_d_reg & ~sda_d_reg & sda;
	wire timeout = (to_cnt_reg >= MS_W * `LSI_TIMEOUT_MS);
	// [RULE12] range step decisions
	wire near_top = (adc_code[15:14] == 2'h3) && (range_sel != RN_MAX);
	wire near_bot = (adc_code[15:12] == 4'h0) && (range_sel != 4'h0);
	// [RULE13] [RULE20] conversion start
	wire conv_go = ~rst & ~cfg_wr_reg & ~busy_reg &
		(cfg_reg[`LSI_M_HI:`LSI_M_LO] != `LSI_MODE_SHUT);
	reg  [15:0] rd_word;

	// [RULE18] read source from pointer
	always @* begin
		case (ptr_reg)
		`LSI_PTR_RESULT: rd_word = result_reg;
		`LSI_PTR_CONFIG: rd_word = cfg_reg;
		default:         rd_word = 16'h0000;
		endcase
	end

	// Pin synchronisers
	always @(posedge clk) begin
		if (rst) begin
			scl_s_reg <= 2'h3;
			sda_s_reg <= 2'h3;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_s_reg <= {scl_s_reg[0], scl_in};
			sda_s_reg <= {sda_s_reg[0], sda_in};
			scl_d_reg <= scl;
			sda_d_reg <= sda;
		end
	end

	// [RULE1] low clock timer
	always @(posedge clk) begin
		if (rst || scl)
			to_cnt_reg <= 32'h0;
		else if (!timeout)
			to_cnt_reg <= to_cnt_reg + 32'h1;
	end

	// Bus state machine
	always @(posedge clk) begin
		cfg_wr_reg <= 1'b0;
		// [RULE1] timeout reset
		if (rst || timeout || stop_c) begin
			state_reg <= S_IDLE;
			sda_out <= 1'b1;
			sda_oe <= 1'b0;
			bit_reg <= 4'h0;
			byte_reg <= 2'h0;
			if (rst) begin
				ptr_reg <= `LSI_PTR_RESULT;
				sh_reg <= 8'h00;
				hi_reg <= 8'h00;
				rw_reg <= 1'b0;
				ack_me_reg <= 1'b0;
				mack_reg <= 1'b0;
				txw_reg <= 16'h0000;
				cfg_wdata_reg <= 16'h0000;
			end
		end else if (start_c) begin
			state_reg <= S_RX;
			bit_reg <= 4'h0;
			byte_reg <= 2'h0;
			sda_oe <= 1'b0;
		end else begin
			case (state_reg)
			S_IDLE: begin
				sda_oe <= 1'b0;
				bit_reg <= 4'h0;
			end
			S_RX: begin
				// [RULE4] shift on rising edge
				if (scl_rise) begin
					sh_reg <= {sh_reg[6:0], sda};
					bit_reg <= bit_reg + 4'h1;
				end
				// [RULE6] eighth bit then acknowledge
				if (scl_fall && bit_reg == 4'h8) begin
					bit_reg <= 4'h0;
					state_reg <= S_ACK;
					if (byte_reg == 2'h0) begin
						// [RULE16] address match
						ack_me_reg <= (sh_reg[7:1] == `LSI_DEV_ADDR);
						rw_reg <= sh_reg[0];
						// [RULE5] acknowledge address
						sda_oe <= (sh_reg[7:1] == `LSI_DEV_ADDR);
						sda_out <= 1'b0;
					end else begin
						// [RULE17] ack each byte
						sda_oe <= 1'b1;
						sda_out <= 1'b0;
						// [RULE18] pointer kept
						if (byte_reg == 2'h1)
							ptr_reg <= sh_reg;
						else if (byte_reg == 2'h2)
							hi_reg <= sh_reg;
						else if (ptr_reg == `LSI_PTR_CONFIG) begin
							cfg_wr_reg <= 1'b1;
							cfg_wdata_reg <= {hi_reg, sh_reg};
						end
					end
					if (byte_reg != 2'h3)
						byte_reg <= byte_reg + 2'h1;
					else
						byte_reg <= 2'h2;
				end
			end
			S_ACK: begin
				if (scl_rise)
					mack_reg <= ~sda;
				if (scl_fall) begin
					if (!ack_me_reg) begin
						state_reg <= S_IDLE;
						sda_oe <= 1'b0;
					end else if (rw_reg && (byte_reg == 2'h1 || mack_reg)) begin
						// [RULE15] word chosen by the pointer (result, config, or zero for other pointers) shifted out MSB first
						state_reg <= S_TX;
						txw_reg <= (byte_reg == 2'h1) ? rd_word : txw_reg;
						sh_reg <= (byte_reg == 2'h1) ? rd_word[15:8] :
							txw_reg[7:0];
						sda_oe <= ~((byte_reg == 2'h1) ? rd_word[15] :
							txw_reg[7]);
						sda_out <= 1'b0;
						bit_reg <= 4'h1;
						byte_reg <= 2'h2;
					end else if (rw_reg) begin
						state_reg <= S_IDLE;
						sda_oe <= 1'b0;
					end else begin
						state_reg <= S_RX;
						sda_oe <= 1'b0;
					end
				end
			end
			S_TX: begin
				if (scl_fall) begin
					if (bit_reg == 4'h8) begin
						bit_reg <= 4'h0;
						sda_oe <= 1'b0;
						state_reg <= S_ACK;
					end else begin
						sda_oe <= ~sh_reg[7 - bit_reg[2:0]];
						bit_reg <= bit_reg + 4'h1;
					end
				end
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end

	// Millisecond tick, restarted with each conversion
	always @(posedge clk) begin
		if (rst || conv_go) begin
			ms_cnt_reg <= 32'h0;
			ms_tick_reg <= 1'b0;
		end else if (ms_cnt_reg == MS_W - 32'h1) begin
			ms_cnt_reg <= 32'h0;
			ms_tick_reg <= 1'b1;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 32'h1;
			ms_tick_reg <= 1'b0;
		end
	end

	// Measurement control
	always @(posedge clk) begin
		if (rst) begin
			// [RULE13] shutdown at reset
			cfg_reg <= `LSI_CFG_RESET;
			result_reg <= 16'h0000;
			busy_reg <= 1'b0;
			ms_left_reg <= 10'h000;
			range_sel <= 4'h0;
			integrating <= 1'b0;
		end else if (cfg_wr_reg) begin
			cfg_reg[15:9] <= cfg_wdata_reg[15:9];
			busy_reg <= 1'b0;
			integrating <= 1'b0;
		end else if (!busy_reg) begin
			// [RULE20] no conversion in shutdown
			if (cfg_reg[`LSI_M_HI:`LSI_M_LO] != `LSI_MODE_SHUT) begin
				busy_reg <= 1'b1;
				integrating <= 1'b1;
				// [RULE9] [RULE10] window select
				ms_left_reg <= cfg_reg[`LSI_CT_BIT] ?
					10'd`LSI_LONG_MS : 10'd`LSI_SHORT_MS;
				// [RULE11] fixed or automatic
				if (cfg_reg[`LSI_RN_HI:`LSI_RN_LO] != `LSI_RN_AUTO)
					range_sel <= cfg_reg[`LSI_RN_HI:`LSI_RN_LO];
			end
		end else if (ms_tick_reg) begin
			if (ms_left_reg == 10'h001 && integrating) begin
				integrating <= 1'b0;
				// [RULE19] readout delay
				ms_left_reg <= 10'd`LSI_READY_MS;
			end else if (ms_left_reg == 10'h001) begin
				// [RULE15] result ready
				result_reg <= adc_code;
				cfg_reg[`LSI_CRF_BIT] <= 1'b1;
				busy_reg <= 1'b0;
				// [RULE12] auto range adjust
				if (cfg_reg[`LSI_RN_HI:`LSI_RN_LO] == `LSI_RN_AUTO) begin
					if (near_top)
						range_sel <= range_sel + 4'h1;
					else if (near_bot)
						range_sel <= range_sel - 4'h1;
				end
				// [RULE14] single shot returns to shutdown
				if (cfg_reg[`LSI_M_HI:`LSI_M_LO] == `LSI_MODE_SINGLE)
					cfg_reg[`LSI_M_HI:`LSI_M_LO] <= `LSI_MODE_SHUT;
			end else
				ms_left_reg <= ms_left_reg - 10'h001;
		end
	end
endmodule // lsi_slave
`default_nettype wire

//--- tb/lsi_assertions.sv
`default_nettype none
module lsi_chk #(
	parameter integer MS_CYCLES = 200000
) (
	// Design ports
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic [15:0] adc_code,
	input wire logic [3:0]  range_sel,
	input wire logic        integrating
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	localparam int S = 100 * MS_CYCLES;
	localparam int L = 800 * MS_CYCLES;
	int lo;
	int ic;
	always @(posedge clk) begin
		lo <= (rst || scl_in) ? 0 : lo + 1;
		ic <= integrating ? ic + 1 : 0;
	end
	sequence s_ack; sda_oe [*8]; endsequence
	sequence s_off; !integrating [*8]; endsequence
	AST_LOW: assert property (disable iff (rst)
		sda_oe |-> !sda_out) else $error("sda driven high");
	AST_RST: assert property (rst |=> !sda_oe && !integrating
		&& range_sel == 4'h0) else $error("reset state");
	AST_UP: assert property ($fell(rst) |-> s_off) else $error("woke");
	AST_MOVE: assert property (disable iff (rst)
		$changed(sda_oe) |-> !scl_in) else $error("sda moved");
	AST_HOLD: assert property (disable iff (rst)
		$rose(sda_oe) |=> s_ack) else $error("ack short");
	AST_TMO: assert property (disable iff (rst)
		lo > 28 * MS_CYCLES + 4 |-> !sda_oe) else $error("no timeout");
	AST_WIN: assert property (disable iff (rst) $fell(integrating)
		|-> ic inside {[S-2:S+2], [L-2:L+2]}) else $error("window");
	AST_RNG: assert property (disable iff (rst)
		integrating && $past(integrating) |-> $stable(range_sel))
		else $error("range moved");
endmodule // lsi_chk
bind lsi_slave lsi_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (.clk(clk),
	.rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .adc_code(adc_code), .range_sel(range_sel),
	.integrating(integrating));
`default_nettype wire

//--- tb/lsi_host.sv
`default_nettype none
module lsi_host (
	// Bus
	input wire logic clk,
	input wire logic sda,
	output logic     scl,
	output logic     sda_low
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic q;
		repeat (10) @(negedge clk);
	endtask
	task automatic start;
		sda_low = 1'b0;
		q;
		scl = 1'b1;
		q;
		sda_low = 1'b1;
		q;
		scl = 1'b0;
		q;
	endtask
	task automatic stop;
		sda_low = 1'b1;
		q;
		scl = 1'b1;
		q;
		sda_low = 1'b0;
		q;
	endtask
	task automatic bitx(input logic b, output logic r);
		sda_low = !b;
		q;
		scl = 1'b1;
		q;
		r = sda;
		q;
		scl = 1'b0;
		q;
	endtask
	task automatic xfer(input logic [7:0] d, input logic b9,
		output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r[i]);
		bitx(b9, a);
	endtask
endmodule // lsi_host
`default_nettype wire

//--- tb/test_light_sensor_i2c_slave.sv
`default_nettype none
module test_light_sensor_i2c_slave;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int MS = 20;
	logic        clk;
	logic        rst;
	logic        scl;
	logic        host_low;
	logic        sda_out;
	logic        sda_oe;
	logic        integrating;
	logic [15:0] adc_code;
	logic [3:0]  range_sel;
	wire logic   sda;
	int          n_fail;
	int          compares;
	assign sda = !(sda_oe || host_low);
	lsi_slave #(.MS_CYCLES(MS)) i_dut (.clk(clk), .rst(rst), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.adc_code(adc_code), .range_sel(range_sel),
		.integrating(integrating));
	lsi_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic reset_dut;
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task automatic send(input logic [7:0] b);
		logic [7:0] r;
		logic       a;
		i_host.xfer(b, 1'b1, r, a);
		check(a, 1'b0);
	endtask
	task automatic wr(input logic [7:0] p, input logic [15:0] d, input bit n);
		i_host.start;
		send(8'h8A);
		send(p);
		if (n) begin
			send(d[15:8]);
			send(d[7:0]);
		end
		i_host.stop;
	endtask
	task automatic rd(input logic [15:0] exp);
		logic [15:0] v;
		logic        a;
		i_host.start;
		send(8'h8B);
		i_host.xfer(8'hFF, 1'b0, v[15:8], a);
		i_host.xfer(8'hFF, 1'b1, v[7:0], a);
		i_host.stop;
		check(v, exp);
	endtask
	task automatic t_bus;
		logic [7:0] b;
		logic [7:0] r;
		logic       a;
		b = 8'h8A;
		i_host.start;
		i_host.xfer(8'h88, 1'b1, r, a);
		check(a, 1'b1);
		i_host.stop;
		i_host.start;
		for (int i = 7; i >= 0; i--)
			i_host.bitx(b[i], a);
		i_host.sda_low = 1'b0;
		repeat (5) @(negedge clk);
		check(sda_oe, 1'b1);
		check(sda_out, 1'b0);
		repeat (28 * MS + 20) @(negedge clk);
		check(sda_oe, 1'b0);
		i_host.stop;
	endtask
	task automatic conv(input logic [15:0] c, d, input int w,
		output logic [3:0] r);
		adc_code = d;
		wr(8'h01, c, 1'b1);
		check(integrating, 1'b1);
		r = range_sel;
		repeat ((w - 4) * MS) @(negedge clk);
		check(integrating, 1'b1);
		repeat (8 * MS) @(negedge clk);
		check(integrating, 1'b0);
		wr(8'h00, 16'h0000, 1'b0);
		rd(d);
	endtask
	// Pointer handling and reset contents
	task automatic t_regs;
		wr(8'h01, 16'h0000, 1'b0);
		rd(16'hC810);
		rd(16'hC810);
		wr(8'h02, 16'h1234, 1'b1);
		rd(16'h0000);
		wr(8'h01, 16'h0000, 1'b0);
		rd(16'hC810);
	endtask
	// Fixed range single shot
	task automatic t_fixed;
		logic [3:0] r;
		conv(16'h3200, 16'h1234, 100, r);
		check(r, 4'h3);
	endtask
	// Automatic range, short then long window
	task automatic t_auto;
		logic [3:0] r1;
		logic [3:0] r2;
		conv(16'hC200, 16'hF000, 100, r1);
		check(r1, 4'h3);
		conv(16'hCA00, 16'hF000, 800, r2);
		check(r2, 4'h4);
	endtask
	// Continuous conversions restart
	task automatic t_cont;
		wr(8'h01, 16'h3400, 1'b1);
		repeat (104 * MS) @(negedge clk);
		check(integrating, 1'b1);
		check(range_sel, 4'h3);
	endtask
	// Reset in mid run
	task automatic t_reset;
		reset_dut;
		wr(8'h01, 16'h0000, 1'b0);
		rd(16'hC810);
		check(integrating, 1'b0);
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (80000) @(posedge clk);
		n_fail++;
		finish_test;
	end
	initial begin
		adc_code = 16'h0000;
		reset_dut;
		t_regs;
		t_bus;
		t_fixed;
		t_auto;
		t_cont;
		t_reset;
		finish_test;
	end
endmodule // test_light_sensor_i2c_slave
`default_nettype wire
